// >>> rtl/bel_event_encoder.sv
/*
 * Event encoder: synchronises the bus-side error inputs and folds one
 * error into a full 64-bit status image in a single register stage.
 * Assumes bus-side inputs arrive asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module bel_event_encoder
	import bel_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic err_strobe,
	input wire logic [5:0] err_request,
	input wire logic [2:0] err_class,
	input wire logic [1:0] err_pp,
	input wire logic err_t,
	input wire logic [3:0] err_rrrr,
	input wire logic [1:0] err_ii,
	input wire logic [1:0] err_ll,
	input wire logic redundancy_check_mismatch,
	input wire logic bus_error_signal_out,
	input wire logic bus_initialise_signal_out,
	input wire logic bus_initialise_signal_in,
	input wire logic split_access,
	input wire logic rsp_strobe,
	input wire logic [2:0] response_status_lines,
	input wire logic response_parity_line,
	bel_event_if.src ev
);
	localparam int W = 31;

	// -----------------------------------------------------------------
	// two-stage synchroniser on every bus-side input
	// -----------------------------------------------------------------
	logic [W-1:0] raw, s1_q, s2_q;
	assign raw = {err_strobe, err_request, err_class, err_pp, err_t,
		err_rrrr, err_ii, err_ll, redundancy_check_mismatch,
		bus_error_signal_out, bus_initialise_signal_out,
		bus_initialise_signal_in, split_access, rsp_strobe,
		response_status_lines, response_parity_line};

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end

	// fields of the synchronised vector
	logic strobe_s, rsp_s, par_bad, hard_split, any_ev;
	logic [5:0] req_s;
	logic [2:0] cls_s;
	assign strobe_s = s2_q[30];
	assign req_s = s2_q[29:24];
	assign cls_s = s2_q[23:21];
	assign rsp_s = s2_q[4];
	// even parity across status and parity lines is expected
	assign par_bad = rsp_s && ^s2_q[3:0];
	assign hard_split = strobe_s && s2_q[5] &&
		cls_s == BEL_HARD_ERROR_CLASS;
	assign any_ev = strobe_s || par_bad;

	// -----------------------------------------------------------------
	// build the whole image at once so fields never mix across errors
	// -----------------------------------------------------------------
	logic [63:0] img_d, img_q;
	logic valid_q;
	always_comb begin
		img_d = '0;
		// pp, t, rrrr, ii, ll sit side by side under the fixed one
		img_d[15:0] = BEL_CODE_BASE | {5'h00, s2_q[20:10]};
		if (strobe_s) begin
			img_d[BEL_RTYPE_LSB +: 6] = req_s;
			img_d[BEL_ECLASS_LSB +: 3] = cls_s;
			img_d[BEL_REDUND_BIT] = s2_q[9];
			img_d[BEL_BUS_ERROR_SIGNAL_BIT] = s2_q[8];
			img_d[BEL_IBINIT_BIT] = s2_q[7];
			img_d[BEL_XBINIT_BIT] = s2_q[6];
		end
		img_d[BEL_RSPPAR_BIT] = par_bad;
		img_d[BEL_SPLIT_BIT] = hard_split;
	end

	// one register stage: all fields captured in the same cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			img_q <= '0;
			valid_q <= 1'b0;
		end else begin
			img_q <= img_d;
			valid_q <= any_ev;
		end
	end

	assign ev.valid = valid_q;
	assign ev.word = img_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	par_flag_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		rsp_s && ^s2_q[3:0] |=> valid_q && img_q[BEL_RSPPAR_BIT])
		else $error("parity failure not flagged");
	split_flag_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		img_q[BEL_SPLIT_BIT] |-> $past(s2_q[5]) && $past(strobe_s))
		else $error("split flag without split hard error");
	cv_parity: cover property (@(posedge clk) disable iff (!reset_n)
		valid_q && img_q[BEL_RSPPAR_BIT]);
endmodule
`default_nettype wire

// >>> rtl/bel_event_if.sv
/*
 * Interface carrying one captured bus error event from the event
 * encoder to the status register. Assumes the core clock on both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface bel_event_if;
	import bel_pkg::*;
	logic valid;
	logic [63:0] word;
	modport src (output valid, output word);
	modport dst (input valid, input word);
endinterface
`default_nettype wire

// >>> rtl/bel_pkg.sv
/*
 * Package for the bus error status logger: register indices, field
 * positions, request-type and error-class codes, reset values.
 * Assumes a single core clock domain and the plain register port.
 */
package bel_pkg;

	// -----------------------------------------------------------------
	// register map (word index on the plain register port)
	// -----------------------------------------------------------------
	localparam logic [3:0] BEL_REG_STATUS_LO = 4'h0;
	localparam logic [3:0] BEL_REG_STATUS_HI = 4'h1;
	localparam logic [3:0] BEL_REG_CTRL = 4'h2;
	localparam logic [3:0] BEL_REG_CAPTURES = 4'h3;
	localparam logic [63:0] BEL_STATUS_RESET = 64'h0;
	localparam logic [0:0] BEL_CTRL_RESET = 1'h1;

	// -----------------------------------------------------------------
	// field positions inside the 64-bit status word
	// -----------------------------------------------------------------
	localparam int BEL_CODE_LSB = 0;
	localparam int BEL_RTYPE_LSB = 19;
	localparam int BEL_ECLASS_LSB = 25;
	localparam int BEL_REDUND_BIT = 28;
	localparam int BEL_BUS_ERROR_SIGNAL_BIT = 29;
	localparam int BEL_IBINIT_BIT = 30;
	localparam int BEL_XBINIT_BIT = 35;
	localparam int BEL_RSPPAR_BIT = 36;
	localparam int BEL_SPLIT_BIT = 37;
	localparam int BEL_VALID_LSB = 57;
	localparam int BEL_VAL_BIT = 63;
	localparam int BEL_OVER_BIT = 62;
	localparam int BEL_UC_BIT = 61;
	localparam int BEL_EN_BIT = 60;
	localparam int BEL_PCC_BIT = 57;

	// writable bits: code, model fields and validity; reserved stay zero
	localparam logic [63:0] BEL_WMASK = 64'hFE00_0038_7FF8_FFFF;

	// compound bus error code template 0000 1PPT RRRR IILL
	localparam logic [15:0] BEL_CODE_BASE = 16'h0800;

	// -----------------------------------------------------------------
	// failing bus-queue request type codes
	// -----------------------------------------------------------------
	typedef enum logic [5:0] {
		BEL_DCACHE_READ_REQUEST = 6'h00,
		BEL_FETCH_DEMAND_REQUEST = 6'h02,
		BEL_FETCH_DEMAND_UNCACHED_REQUEST = 6'h03,
		BEL_READ_FOR_OWNERSHIP_REQUEST = 6'h04,
		BEL_LOCKED_OWNERSHIP_READ_REQUEST = 6'h05,
		BEL_INVALIDATE_TO_MODIFIED_REQUEST = 6'h06,
		BEL_WRITEBACK_REQUEST = 6'h08,
		BEL_COMBINING_EVICT_REQUEST = 6'h0A,
		BEL_COMBINING_LINE_REQUEST = 6'h0B,
		BEL_BRANCH_TRACE_REQUEST = 6'h0C,
		BEL_INTERRUPT_ACK_REQUEST = 6'h0D,
		BEL_L2_INVALIDATE_ALL_REQUEST = 6'h0E,
		BEL_L2_FLUSH_REQUEST = 6'h0F,
		BEL_PARTIAL_READ_REQUEST = 6'h10,
		BEL_PARTIAL_WRITE_REQUEST = 6'h12,
		BEL_SPECIAL_CYCLE_REQUEST = 6'h14,
		BEL_IO_SPACE_READ_REQUEST = 6'h18,
		BEL_IO_SPACE_WRITE_REQUEST = 6'h19,
		BEL_LOCKED_READ_REQUEST = 6'h1C,
		BEL_LOCKED_WRITE_REQUEST = 6'h1D,
		BEL_SPLIT_LOCKED_READ_REQUEST = 6'h1E
	} bel_rtype_t;

	// -----------------------------------------------------------------
	// bus error class codes
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		BEL_HARD_ERROR_CLASS = 3'h0,
		BEL_DOUBLE_ERROR_CLASS = 3'h1,
		BEL_SECOND_ADDR_PARITY_CLASS = 3'h2,
		BEL_SINGLE_ERROR_CLASS = 3'h4,
		BEL_FIRST_ADDR_PARITY_CLASS = 3'h5
	} bel_eclass_t;

endpackage

// >>> rtl/bus_error_status_logger.sv
/*
 * Bus error status logger top: holds the 64-bit bank error status
 * register and its plain register port. Assumes a single 100 MHz core
 * clock, synchronous active-low reset and bus-side inputs from pins.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_error_status_logger
	import bel_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic err_strobe,
	input wire logic [5:0] err_request,
	input wire logic [2:0] err_class,
	input wire logic [1:0] err_pp,
	input wire logic err_t,
	input wire logic [3:0] err_rrrr,
	input wire logic [1:0] err_ii,
	input wire logic [1:0] err_ll,
	input wire logic redundancy_check_mismatch,
	input wire logic bus_error_signal_out,
	input wire logic bus_initialise_signal_out,
	input wire logic bus_initialise_signal_in,
	input wire logic split_access,
	input wire logic rsp_strobe,
	input wire logic [2:0] response_status_lines,
	input wire logic response_parity_line,
	output logic error_logged
);

	// -----------------------------------------------------------------
	// event capture
	// -----------------------------------------------------------------
	bel_event_if ev ();

	bel_event_encoder u_enc (
		.clk(clk),
		.reset_n(reset_n),
		.err_strobe(err_strobe),
		.err_request(err_request),
		.err_class(err_class),
		.err_pp(err_pp),
		.err_t(err_t),
		.err_rrrr(err_rrrr),
		.err_ii(err_ii),
		.err_ll(err_ll),
		.redundancy_check_mismatch(redundancy_check_mismatch),
		.bus_error_signal_out(bus_error_signal_out),
		.bus_initialise_signal_out(bus_initialise_signal_out),
		.bus_initialise_signal_in(bus_initialise_signal_in),
		.split_access(split_access),
		.rsp_strobe(rsp_strobe),
		.response_status_lines(response_status_lines),
		.response_parity_line(response_parity_line),
		.ev(ev)
	);

	// -----------------------------------------------------------------
	// control: logging enable, steers capture
	// -----------------------------------------------------------------
	logic log_en_q;
	logic [15:0] cap_cnt_q;
	logic wr_lo, wr_hi, wr_ctrl;
	assign wr_lo = reg_write && reg_addr == BEL_REG_STATUS_LO;
	assign wr_hi = reg_write && reg_addr == BEL_REG_STATUS_HI;
	assign wr_ctrl = reg_write && reg_addr == BEL_REG_CTRL;

	always_ff @(posedge clk) begin
		if (!reset_n)
			log_en_q <= BEL_CTRL_RESET;
		else if (wr_ctrl)
			log_en_q <= reg_wdata[0];
	end

	// -----------------------------------------------------------------
	// status register: hardware capture wins over software write
	// -----------------------------------------------------------------
	logic [63:0] status_q, status_d, sw_d;
	logic capture;
	assign capture = ev.valid && log_en_q;

	// a capture in the cycle of a software clear keeps the held word and
	// marks overflow: the clear is lost rather than the error, the safer
	// way round for a handler that polls, reads and then clears

	always_comb begin
		sw_d = status_q;
		if (wr_lo)
			sw_d[31:0] = reg_wdata;
		if (wr_hi)
			sw_d[63:32] = reg_wdata;
		sw_d = sw_d & BEL_WMASK;
		status_d = sw_d;
		if (capture) begin
			if (status_q[BEL_VAL_BIT]) begin
				// keep first error, note the loss
				status_d = status_q;
				status_d[BEL_OVER_BIT] = 1'b1;
			end else begin
				status_d = ev.word & BEL_WMASK;
				status_d[BEL_VAL_BIT] = 1'b1;
				status_d[BEL_EN_BIT] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			status_q <= BEL_STATUS_RESET;
		else
			status_q <= status_d;
	end

	// count of captured errors, visible state
	always_ff @(posedge clk) begin
		if (!reset_n)
			cap_cnt_q <= '0;
		else if (capture && cap_cnt_q != 16'hFFFF)
			cap_cnt_q <= cap_cnt_q + 16'h0001;
	end

	// -----------------------------------------------------------------
	// read port: data one cycle after strobe, unmapped reads zero
	// -----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n)
			reg_rdata <= '0;
		else if (reg_read) begin
			case (reg_addr)
				BEL_REG_STATUS_LO: reg_rdata <= status_q[31:0];
				BEL_REG_STATUS_HI: reg_rdata <= status_q[63:32];
				BEL_REG_CTRL: reg_rdata <= {31'h0, log_en_q};
				BEL_REG_CAPTURES: reg_rdata <= {16'h0, cap_cnt_q};
				default: reg_rdata <= '0;
			endcase
		end else
			reg_rdata <= '0;
	end

	assign error_logged = status_q[BEL_VAL_BIT];

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	// helper views of the held word
	logic [2:0] held_class;
	logic held_valid, held_over, write_any;
	assign held_class = status_q[BEL_ECLASS_LSB +: 3];
	assign held_valid = status_q[BEL_VAL_BIT];
	assign held_over = status_q[BEL_OVER_BIT];
	assign write_any = wr_lo || wr_hi;

	// reserved bits stay zero; capture of a fresh error into an empty register
	rsvd_zero_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(status_q & ~BEL_WMASK) == 64'h0)
		else $error("reserved status bit set");
	code_form_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture && !held_valid |=> status_q[15:11] == 5'h01)
		else $error("error code not compound bus form");
	code_copy_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture && !held_valid |=>
		status_q[15:0] == $past(ev.word[15:0]))
		else $error("error code not captured");
	rtype_copy_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture && !held_valid |=>
		status_q[24:19] == $past(ev.word[24:19]))
		else $error("request type not captured");
	class_copy_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture && !held_valid |=>
		status_q[27:25] == $past(ev.word[27:25]))
		else $error("error class not captured");
	flags_copy_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture && !held_valid |=>
		status_q[30:28] == $past(ev.word[30:28]) &&
		status_q[37:35] == $past(ev.word[37:35]))
		else $error("flags captured apart from fields");
	split_hard_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture && !held_valid && ev.word[BEL_SPLIT_BIT] |=>
		held_class == BEL_HARD_ERROR_CLASS)
		else $error("split flag with a soft error class");
	valid_set_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture |=> held_valid)
		else $error("valid not set after capture");
	en_set_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture && !held_valid |=> status_q[BEL_EN_BIT])
		else $error("enabled flag not set after capture");

	// holding, overflow and stickiness until software clears
	overflow_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture && held_valid |=>
		held_over && $stable(status_q[37:0]))
		else $error("second error overwrote first");
	valid_keep_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		held_valid && !wr_hi |=> held_valid)
		else $error("valid dropped without a write");
	over_keep_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		held_over && !wr_hi |=> held_over)
		else $error("overflow dropped without a write");
	hold_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		!capture && !write_any |=> $stable(status_q))
		else $error("status changed with no cause");

	// status writes land masked unless a capture takes the cycle; control writes land regardless
	wr_lo_land_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		wr_lo && !capture |=>
		status_q[31:0] == ($past(reg_wdata) & BEL_WMASK[31:0]))
		else $error("low status write not applied");
	wr_hi_land_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		wr_hi && !capture |=>
		status_q[63:32] == ($past(reg_wdata) & BEL_WMASK[63:32]))
		else $error("high status write not applied");
	ctrl_write_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		wr_ctrl |=> log_en_q == $past(reg_wdata[0]))
		else $error("log enable write not applied");

	// read port: one cycle of data after the strobe, zero otherwise
	read_lat_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		reg_read && reg_addr == BEL_REG_CTRL |=>
		reg_rdata == {31'h0, $past(log_en_q)})
		else $error("control readback wrong");
	read_lo_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		reg_read && reg_addr == BEL_REG_STATUS_LO |=>
		reg_rdata == $past(status_q[31:0]))
		else $error("low status readback wrong");
	read_hi_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		reg_read && reg_addr == BEL_REG_STATUS_HI |=>
		reg_rdata == $past(status_q[63:32]))
		else $error("high status readback wrong");
	read_cnt_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		reg_read && reg_addr == BEL_REG_CAPTURES |=>
		reg_rdata == {16'h0, $past(cap_cnt_q)})
		else $error("capture count readback wrong");
	rdata_idle_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		!reg_read |=> reg_rdata == 32'h0)
		else $error("read data outside its cycle");

	// capture counter: one step per capture, saturating
	count_step_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		capture && cap_cnt_q != 16'hFFFF |=>
		cap_cnt_q == $past(cap_cnt_q) + 16'h0001)
		else $error("capture count did not step");
	count_hold_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		!capture |=> $stable(cap_cnt_q))
		else $error("capture count moved without capture");

	// main scenarios worth seeing at least once
	cv_log: cover property (@(posedge clk) disable iff (!reset_n) capture);
	cv_over: cover property (@(posedge clk) disable iff (!reset_n)
		capture && status_q[BEL_VAL_BIT]);
	cv_clear: cover property (@(posedge clk) disable iff (!reset_n)
		status_q[BEL_VAL_BIT] ##1 !status_q[BEL_VAL_BIT]);
	cv_split: cover property (@(posedge clk) disable iff (!reset_n)
		capture && ev.word[BEL_SPLIT_BIT]);
endmodule
`default_nettype wire

// >>> tb/bel_bus_agent.sv
/*
 * Far-side bus agent model: raises logged error events and response
 * status checks for the status logger.
 * Assumes the logger samples all its bus-side inputs on the rising clk.
 */
`timescale 1ns/1ps
`default_nettype none
module bel_bus_agent (
	input wire logic clk,
	output logic err_strobe,
	output logic [19:0] fld,
	output logic [4:0] flg,
	output logic rsp_strobe,
	output logic [2:0] rsp_lines,
	output logic rsp_par
);
	// -----------------------------------------------------------------
	// idle state and event tasks
	// -----------------------------------------------------------------
	// idle lines at time zero
	initial begin
		err_strobe = 1'b0;
		fld = 20'h0;
		flg = 5'h0;
		rsp_strobe = 1'b0;
		rsp_lines = 3'h0;
		rsp_par = 1'b0;
	end

	// one error cycle; released fields flip so stale values never match
	task send(input logic [19:0] f, input logic [4:0] g);
		@(posedge clk);
		err_strobe <= 1'b1;
		fld <= f;
		flg <= g;
		@(posedge clk);
		err_strobe <= 1'b0;
		fld <= ~f;
		flg <= ~g;
	endtask

	// response check cycle; bad set only where a test wants a failure
	task respond(input logic [2:0] s, input logic bad);
		@(posedge clk);
		rsp_strobe <= 1'b1;
		rsp_lines <= s;
		rsp_par <= (^s) ^ bad;
		@(posedge clk);
		rsp_strobe <= 1'b0;
		rsp_lines <= ~s;
		rsp_par <= ~((^s) ^ bad);
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_bus_error_status_logger.sv
/*
 * Self-checking bench for the bus error status logger.
 * Assumes the far-side agent model and the design files compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_bus_error_status_logger;
	import bel_pkg::*;
	logic clk, reset_n, reg_write, reg_read, error_logged;
	logic err_strobe, rsp_strobe, rsp_par;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, lo, hi;
	logic [19:0] fld, fa;
	logic [4:0] flg, ga;
	logic [2:0] rsp_lines;
	logic [63:0] e;
	int num_errors, checked;
	bel_rtype_t r;
	bel_eclass_t c;

	bel_bus_agent bel_bus_agent_i (.clk(clk), .err_strobe(err_strobe),
		.fld(fld), .flg(flg), .rsp_strobe(rsp_strobe),
		.rsp_lines(rsp_lines), .rsp_par(rsp_par));
	bus_error_status_logger bus_error_status_logger_i (.clk(clk),
		.reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.err_strobe(err_strobe), .err_request(fld[19:14]),
		.err_class(fld[13:11]), .err_pp(fld[10:9]), .err_t(fld[8]),
		.err_rrrr(fld[7:4]), .err_ii(fld[3:2]), .err_ll(fld[1:0]),
		.redundancy_check_mismatch(flg[0]), .bus_error_signal_out(flg[1]),
		.bus_initialise_signal_out(flg[2]),
		.bus_initialise_signal_in(flg[3]), .split_access(flg[4]),
		.rsp_strobe(rsp_strobe), .response_status_lines(rsp_lines),
		.response_parity_line(rsp_par), .error_logged(error_logged));

	// -----------------------------------------------------------------
	// clock and shared tasks
	// -----------------------------------------------------------------
	// 100 MHz core clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task check(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, x);
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task clr;
		wr(4'h0, 32'h0);
		wr(4'h1, 32'h0);
	endtask

	// bounded wait for a capture; a hang ends the run
	task wait_log;
		int n;
		n = 0;
		while (error_logged !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		if (error_logged !== 1'b1) begin
			num_errors++;
			$display("MISMATCH t=%0t no capture seen", $time);
			test_done();
		end
	endtask

	// expected 64-bit image; valid and enable flags set on every capture
	function automatic logic [63:0] img(logic [19:0] f, logic [4:0] g);
		img = 64'h0;
		img[15:0] = {5'h01, f[10:0]};
		img[24:19] = f[19:14];
		img[27:25] = f[13:11];
		img[30:28] = g[2:0];
		img[35] = g[3];
		img[37] = g[4] && f[13:11] == BEL_HARD_ERROR_CLASS;
		img[63] = 1'b1;
		img[60] = 1'b1;
	endfunction

	task test_done;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// -----------------------------------------------------------------
	// test sequence
	// -----------------------------------------------------------------
	initial begin
		num_errors = 0;
		checked = 0;
		reset_n = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(4'h0, lo);
		check(lo, 32'h0);
		rd(4'h1, hi);
		check(hi, 32'h0);
		rd(4'h7, lo);
		check(lo, 32'h0);
		$display("test reset done");
		// every request code once; error classes cycle alongside
		r = r.first();
		c = c.first();
		for (int i = 0; i < 21; i++) begin
			// split marks come with soft classes too, for i of 16 to 19
			fa = {r, c, 11'(i * 93 + 5)};
			ga = 5'(i);
			e = img(fa, ga);
			clr();
			bel_bus_agent_i.send(fa, ga);
			wait_log();
			rd(4'h0, lo);
			check(lo, e[31:0]);
			check(32'(lo[24:19]), 32'(r));
			check(32'(lo[27:25]), 32'(c));
			check(32'(lo[30:28]), 32'(ga[2:0]));
			rd(4'h1, hi);
			check(hi, e[63:32]);
			r = r.next();
			c = c.next();
		end
		$display("test encodings done");
		// a second error while valid must not tear the first one
		clr();
		fa = {BEL_LOCKED_WRITE_REQUEST, BEL_DOUBLE_ERROR_CLASS, 11'h5A3};
		e = img(fa, 5'h0B);
		bel_bus_agent_i.send(fa, 5'h0B);
		wait_log();
		bel_bus_agent_i.send(~fa, 5'h14);
		repeat (6) @(posedge clk);
		rd(4'h0, lo);
		check(lo, e[31:0]);
		rd(4'h1, hi);
		check(hi, e[63:32] | 32'h4000_0000);
		$display("test overflow done");
		// response parity: bad parity logs, good parity does not
		clr();
		bel_bus_agent_i.respond(3'h5, 1'b1);
		wait_log();
		rd(4'h1, hi);
		check(hi & 32'h8000_0010, 32'h8000_0010);
		clr();
		bel_bus_agent_i.respond(3'h2, 1'b0);
		repeat (6) @(posedge clk);
		#1 check({31'h0, error_logged}, 32'h0);
		$display("test parity done");
		// logging off: an error is dropped and the count stands still
		wr(4'h2, 32'h0);
		rd(4'h2, lo);
		check(lo, 32'h0);
		bel_bus_agent_i.send(fa, 5'h01);
		repeat (6) @(posedge clk);
		#1 check({31'h0, error_logged}, 32'h0);
		wr(4'h2, 32'h1);
		// 21 encodings, two in the overflow test, one parity failure
		rd(4'h3, lo);
		check(lo, 32'h18);
		$display("test enable done");
		// reserved positions read zero whatever is written
		wr(4'h0, 32'hFFFF_FFFF);
		wr(4'h1, 32'hFFFF_FFFF);
		rd(4'h0, lo);
		check(lo, 32'h7FF8_FFFF);
		rd(4'h1, hi);
		check(hi, 32'hFE00_0038);
		clr();
		$display("test reserved done");
		test_done();
	end
endmodule
`default_nettype wire
